//--- hw/axis_node_pkg.sv
// Constants and carrier types for the remote axis frame interpreter
package axis_node_pkg;

    localparam int          FRAME_DEPTH     = 64;
    localparam int          WORD_W          = 16;
    localparam int          GP_W            = 8;

    localparam logic [15:0] CMD_FEED_WR     = 16'h00B0;
    localparam logic [15:0] CMD_LOW_WR      = 16'h00B1;
    localparam logic [15:0] CMD_HIGH_WR     = 16'h00B2;
    localparam logic [15:0] CMD_ACCEL_WR    = 16'h00B3;
    localparam logic [15:0] CMD_SCALE_WR    = 16'h00B5;
    localparam logic [15:0] CMD_MODE_WR     = 16'h00B7;
    localparam logic [15:0] CMD_START_ACD   = 16'h0053;
    localparam logic [15:0] CMD_CAPTURE     = 16'h0029;
    localparam logic [15:0] CMD_READ_CAP1   = 16'h00ED;
    localparam logic [15:0] CMD_READ_CAP2   = 16'h00EE;
    localparam logic [15:0] CMD_READ_CAP3   = 16'h00EF;
    localparam logic [15:0] CMD_INT_CLEAR   = 16'h0008;

    // Main status field positions
    localparam int          ST_ANY_IRQ      = 0;
    localparam int          ST_STOP_END     = 1;
    localparam int          ST_ERROR        = 2;
    localparam int          ST_EVENT        = 3;
    localparam int          ST_SIM_STOP_LO  = 4;
    localparam int          ST_OP_FULL      = 6;
    localparam int          ST_CMP_FULL     = 7;
    localparam int          ST_BUSY         = 8;
    localparam int          ST_ALIGN_LO     = 9;
    localparam int          ST_GROUP_LO     = 12;

    localparam logic [31:0] PREREG_RST      = 32'h0000_0000;
    localparam logic [7:0]  GP_OUT_RST      = 8'h00;
    localparam logic [15:0] STATUS_RST      = 16'h0000;
    localparam logic [2:0]  GROUP_FROM_PINS = 3'h0;

    typedef enum logic [2:0] {
        S_LOAD  = 3'b000,
        S_FETCH = 3'b001,
        S_EXEC  = 3'b010,
        S_RESP  = 3'b011,
        S_DONE  = 3'b100
    } interp_state_t;

    typedef enum logic [1:0] {
        K_CMD = 2'b00,
        K_LO  = 2'b01,
        K_HI  = 2'b10
    } word_kind_t;

    typedef struct packed {
        logic [31:0] feed_amount;
        logic [31:0] low_speed;
        logic [31:0] high_speed;
        logic [31:0] accel_rate;
        logic [31:0] speed_scale;
        logic [31:0] operation_mode;
    } prereg_set_t;

    typedef struct packed {
        logic       stop_pulse;
        logic       error_flag;
        logic       event_flag;
        logic       op_prereg_full;
        logic       cmp_prereg_full;
        logic       busy;
        logic       irq_masked;
        logic [1:0] sim_stop_bits;
        logic [6:0] clock_align_status;
    } axis_state_t;

endpackage

//--- hw/frame_word_mem.sv
// Frame word buffer with registered read data
`timescale 1ns/10ps
`default_nettype none
module frame_word_mem #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 64
) (
    input  wire logic                     clk,
    input  wire logic                     wr_en,
    input  wire logic [$clog2(DEPTH)-1:0] wr_addr,
    input  wire logic [WIDTH-1:0]         wr_data,
    input  wire logic [$clog2(DEPTH)-1:0] rd_addr,
    output logic      [WIDTH-1:0]         rd_data
);
    logic [WIDTH-1:0] mem [DEPTH];

    initial
    begin
        if (DEPTH < 2 || WIDTH < 1)
        begin
            $error("frame_word_mem: bad geometry");
        end
    end

    always_ff @(posedge clk)
    begin
        if (wr_en)
        begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule
`default_nettype wire

//--- hw/axis_frame_node.sv
// Remote axis node: frame command interpreter and cyclic port mapping
// Functional notes
// RULE_01 - Center loads frame, then starts transfer
// RULE_02 - Write: command, lower half, upper half
// RULE_03 - 00B0h writes feed amount pre-register
// RULE_04 - 00B1h-00B3h write low, high, accel
// RULE_05 - 00B5h scale, 00B7h mode pre-registers
// RULE_06 - 0053h starts accel-cruise-decel, no data
// RULE_07 - Capture command copies all three counters
// RULE_08 - 00EDh-00EFh read capture registers one-three
// RULE_09 - Reply: echo, lower half, upper half
// RULE_10 - Port 3 written; ports 0-2 read
// RULE_11 - Ports: gp out, gp in, status bytes
// RULE_12 - Each terminal direction set by own bit
// RULE_13 - Output data drives only output terminals
// RULE_14 - Watchdog timeout may clear output data
// RULE_15 - Input port reads back output terminal levels
// RULE_16 - Default status layout with group number
// RULE_17 - Align enable swaps high bits, bits 5-4; code swaps bits 5-4 on clock_align_select_b, not align enable
// RULE_18 - Any-interrupt: stop, error or event, unmasked
// RULE_19 - Stop-end sticky, cleared by clear command
// RULE_20 - Group from pins when field zero
// RULE_21 - Center keeps frames within 64 words
// RULE_22 - Frame commands execute strictly in order
`timescale 1ns/10ps
`default_nettype none
module axis_frame_node
    import axis_node_pkg::*;
#(
    parameter int DEPTH = axis_node_pkg::FRAME_DEPTH
) (
    input  wire logic                       clk,
    input  wire logic                       sys_rst,
    input  wire logic                       frame_valid,
    input  wire logic [15:0]                frame_word,
    input  wire logic                       frame_end,
    output logic                            frame_ready,
    output logic                            frame_done,
    output logic                            resp_valid,
    output logic [15:0]                     resp_word,
    input  wire logic [31:0]                counter_one,
    input  wire logic [31:0]                counter_two,
    input  wire logic [31:0]                counter_three,
    output axis_node_pkg::prereg_set_t      prereg,
    output logic                            accel_cruise_decel_start,
    input  wire axis_node_pkg::axis_state_t axis_state,
    input  wire logic                       clock_align_enable,
    input  wire logic                       clock_align_select_b,
    input  wire logic [2:0]                 group_select_field,
    input  wire logic [2:0]                 group_select_pins_n,
    input  wire logic [7:0]                 terminal_direction_bit,
    input  wire logic                       watchdog_timeout,
    input  wire logic                       watchdog_output_clear_pin,
    input  wire logic                       port3_write,
    input  wire logic [7:0]                 port3_data,
    output logic [7:0]                      gp_output_data_port,
    output logic [7:0]                      gp_input_data_port,
    output logic [7:0]                      status_high_byte_port,
    output logic [7:0]                      status_low_byte_port,
    input  wire logic [7:0]                 gp_pin_in,
    output logic [7:0]                      gp_pin_out,
    output logic [7:0]                      gp_pin_oe
);
    import axis_node_pkg::*;

    localparam int AW = $clog2(DEPTH);

    initial
    begin
        if (DEPTH < 2 || DEPTH != (1 << AW))
        begin
            $error("axis_frame_node: DEPTH must be a power of two");
        end
    end

    interp_state_t state_reg;
    word_kind_t    kind_reg;
    logic [AW:0]   len_reg;
    logic [AW:0]   ptr_reg;
    logic [15:0]   rd_data;
    logic [15:0]   word_in;
    logic [2:0]    wr_idx_reg;
    logic [15:0]   lo_reg;
    logic [1:0]    rd_idx_reg;
    logic [1:0]    resp_step_reg;
    logic [31:0]   cap_reg [3];
    logic          capture_now;
    logic          int_clear;
    logic          stop_end_reg;
    logic          mem_wr;
    logic [7:0]    gp_meta_reg;
    logic [7:0]    gp_sync_reg;
    logic [2:0]    grp_meta_reg;
    logic [2:0]    grp_sync_reg;
    logic          wdc_meta_reg;
    logic          wdc_sync_reg;
    logic [2:0]    group_now;
    logic [15:0]   status_next;

    assign mem_wr = (state_reg == S_LOAD) && frame_valid && (len_reg < DEPTH[AW:0]);

    frame_word_mem #(
        .WIDTH (16),
        .DEPTH (DEPTH)
    ) u_mem (
        .clk     (clk),
        .wr_en   (mem_wr),
        .wr_addr (len_reg[AW-1:0]),
        .wr_data (frame_word),
        .rd_addr (ptr_reg[AW-1:0]),
        .rd_data (rd_data)
    );

    // Missing data words of a truncated frame read as zero
    assign word_in = (ptr_reg < len_reg) ? rd_data : 16'h0000;
    assign capture_now = (state_reg == S_EXEC) && (kind_reg == K_CMD)
                         && (ptr_reg < len_reg) && (word_in == CMD_CAPTURE);
    assign int_clear = (state_reg == S_EXEC) && (kind_reg == K_CMD)
                       && (ptr_reg < len_reg) && (word_in == CMD_INT_CLEAR);

    // Frame interpreter: load whole frame, then walk it word by word
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_reg                <= S_LOAD;
            kind_reg                 <= K_CMD;
            len_reg                  <= '0;
            ptr_reg                  <= '0;
            wr_idx_reg               <= 3'h0;
            lo_reg                   <= 16'h0000;
            rd_idx_reg               <= 2'h0;
            resp_step_reg            <= 2'h0;
            frame_ready              <= 1'b1;
            frame_done               <= 1'b0;
            resp_valid               <= 1'b0;
            resp_word                <= 16'h0000;
            accel_cruise_decel_start <= 1'b0;
            prereg                   <= {6{PREREG_RST}};
        end
        else
        begin
            frame_done               <= 1'b0;
            accel_cruise_decel_start <= 1'b0;
            resp_valid               <= 1'b0;
            case (state_reg)
                S_LOAD:
                begin
                    if (mem_wr)
                    begin
                        len_reg <= len_reg + 1'b1;
                    end
                    if (frame_valid && frame_end)
                    begin
                        state_reg   <= S_FETCH;
                        frame_ready <= 1'b0;
                        ptr_reg     <= '0;
                        kind_reg    <= K_CMD;
                    end
                end
                S_FETCH:
                begin
                    state_reg <= S_EXEC;
                end
                S_EXEC:
                begin
                    ptr_reg   <= ptr_reg + 1'b1;
                    state_reg <= S_FETCH;
                    case (kind_reg)
                        K_CMD:
                        begin
                            if (ptr_reg >= len_reg)
                            begin
                                state_reg <= S_DONE;
                            end
                            else
                            begin
                                case (word_in)
                                    CMD_FEED_WR, CMD_LOW_WR, CMD_HIGH_WR, CMD_ACCEL_WR,
                                    CMD_SCALE_WR, CMD_MODE_WR:
                                    begin
                                        wr_idx_reg <= word_in[2:0]; // RULE_03 RULE_04 RULE_05
                                        kind_reg   <= K_LO; // RULE_02
                                    end
                                    CMD_START_ACD:
                                    begin
                                        accel_cruise_decel_start <= 1'b1; // RULE_06 RULE_22
                                    end
                                    CMD_READ_CAP1, CMD_READ_CAP2, CMD_READ_CAP3:
                                    begin
                                        rd_idx_reg    <= 2'(word_in - CMD_READ_CAP1); // RULE_08
                                        resp_valid    <= 1'b1;
                                        resp_word     <= word_in; // RULE_09
                                        resp_step_reg <= 2'h1;
                                        state_reg     <= S_RESP;
                                    end
                                    default:
                                    begin
                                        kind_reg <= K_CMD;
                                    end
                                endcase
                            end
                        end
                        K_LO:
                        begin
                            lo_reg   <= word_in;
                            kind_reg <= K_HI;
                        end
                        K_HI:
                        begin
                            kind_reg <= K_CMD;
                            case (wr_idx_reg)
                                3'h0: prereg.feed_amount    <= {word_in, lo_reg}; // RULE_03
                                3'h1: prereg.low_speed      <= {word_in, lo_reg}; // RULE_04
                                3'h2: prereg.high_speed     <= {word_in, lo_reg};
                                3'h3: prereg.accel_rate     <= {word_in, lo_reg};
                                3'h5: prereg.speed_scale    <= {word_in, lo_reg}; // RULE_05
                                3'h7: prereg.operation_mode <= {word_in, lo_reg};
                                default: prereg.feed_amount <= prereg.feed_amount;
                            endcase
                        end
                        default:
                        begin
                            kind_reg <= K_CMD;
                        end
                    endcase
                end
                S_RESP:
                begin
                    resp_valid <= 1'b1;
                    if (resp_step_reg == 2'h1)
                    begin
                        resp_word     <= cap_reg[rd_idx_reg][15:0]; // RULE_09
                        resp_step_reg <= 2'h2;
                    end
                    else
                    begin
                        resp_word     <= cap_reg[rd_idx_reg][31:16];
                        resp_step_reg <= 2'h0;
                        state_reg     <= S_FETCH;
                    end
                end
                S_DONE:
                begin
                    frame_done  <= 1'b1;
                    frame_ready <= 1'b1;
                    len_reg     <= '0;
                    ptr_reg     <= '0;
                    state_reg   <= S_LOAD;
                end
                default:
                begin
                    state_reg <= S_LOAD;
                end
            endcase
        end
    end

    // Counter capture, all three in one edge
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            cap_reg[0] <= 32'h0000_0000;
            cap_reg[1] <= 32'h0000_0000;
            cap_reg[2] <= 32'h0000_0000;
        end
        else if (capture_now)
        begin
            cap_reg[0] <= counter_one; // RULE_07
            cap_reg[1] <= counter_two;
            cap_reg[2] <= counter_three;
        end
    end

    // Pin synchronisers
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            gp_meta_reg  <= 8'h00;
            gp_sync_reg  <= 8'h00;
            grp_meta_reg <= 3'h7;
            grp_sync_reg <= 3'h7;
            wdc_meta_reg <= 1'b0;
            wdc_sync_reg <= 1'b0;
        end
        else
        begin
            gp_meta_reg  <= gp_pin_in;
            gp_sync_reg  <= gp_meta_reg;
            grp_meta_reg <= group_select_pins_n;
            grp_sync_reg <= grp_meta_reg;
            wdc_meta_reg <= watchdog_output_clear_pin;
            wdc_sync_reg <= wdc_meta_reg;
        end
    end

    // Stop-end sticky flag, a new stop beats the clear
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            stop_end_reg <= 1'b0;
        end
        else if (axis_state.stop_pulse)
        begin
            stop_end_reg <= 1'b1; // RULE_19
        end
        else if (int_clear)
        begin
            stop_end_reg <= 1'b0; // RULE_19
        end
    end

    assign group_now = (group_select_field == GROUP_FROM_PINS) ? ~grp_sync_reg
                                                              : group_select_field; // RULE_20

    always_comb
    begin
        status_next              = STATUS_RST; // RULE_16
        status_next[ST_STOP_END] = stop_end_reg;
        status_next[ST_ERROR]    = axis_state.error_flag;
        status_next[ST_EVENT]    = axis_state.event_flag;
        status_next[ST_ANY_IRQ]  = (stop_end_reg | axis_state.error_flag
                                    | axis_state.event_flag) & ~axis_state.irq_masked; // RULE_18
        status_next[ST_OP_FULL]  = axis_state.op_prereg_full;
        status_next[ST_CMP_FULL] = axis_state.cmp_prereg_full;
        status_next[ST_BUSY]     = axis_state.busy;
        if (clock_align_enable)
        begin
            status_next[15:ST_ALIGN_LO] = axis_state.clock_align_status; // RULE_17
        end
        else
        begin
            status_next[ST_GROUP_LO+2:ST_GROUP_LO] = group_now; // RULE_16
        end
        if (clock_align_select_b)
        begin
            status_next[ST_SIM_STOP_LO+1:ST_SIM_STOP_LO] = axis_state.sim_stop_bits; // RULE_17
        end
    end

    // Cyclic ports and general-purpose terminals
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            gp_output_data_port   <= GP_OUT_RST;
            gp_input_data_port    <= 8'h00;
            status_high_byte_port <= 8'h00;
            status_low_byte_port  <= 8'h00;
            gp_pin_out            <= GP_OUT_RST;
            gp_pin_oe             <= 8'h00;
        end
        else
        begin
            if (watchdog_timeout && wdc_sync_reg)
            begin
                gp_output_data_port <= GP_OUT_RST; // RULE_14
            end
            else if (port3_write)
            begin
                gp_output_data_port <= port3_data; // RULE_10 RULE_11
            end
            gp_pin_out            <= gp_output_data_port & terminal_direction_bit; // RULE_13
            gp_pin_oe             <= terminal_direction_bit; // RULE_12
            gp_input_data_port    <= (gp_sync_reg & ~gp_pin_oe)
                                     | (gp_pin_out & gp_pin_oe); // RULE_15
            status_high_byte_port <= status_next[15:8]; // RULE_11
            status_low_byte_port  <= status_next[7:0];
        end
    end

    a_start_pulse: assert property (@(posedge clk) disable iff (sys_rst) // RULE_06
        (state_reg == S_EXEC && kind_reg == K_CMD && ptr_reg < len_reg
         && word_in == CMD_START_ACD) |=> accel_cruise_decel_start)
        else $error("start command gave no start pulse");
    a_capture_copy: assert property (@(posedge clk) disable iff (sys_rst) // RULE_07
        capture_now |=> (cap_reg[0] == $past(counter_one) && cap_reg[2] == $past(counter_three)))
        else $error("counters not captured together");
    a_read_reply: assert property (@(posedge clk) disable iff (sys_rst) // RULE_09
        (capture_now == 1'b0 && state_reg == S_EXEC && kind_reg == K_CMD && ptr_reg < len_reg
         && word_in == CMD_READ_CAP1)
        |=> (resp_valid && resp_word == CMD_READ_CAP1) ##1 (resp_valid
            && resp_word == cap_reg[0][15:0]) ##1 (resp_valid && resp_word == cap_reg[0][31:16]))
        else $error("read reply sequence wrong");
    a_feed_write: assert property (@(posedge clk) disable iff (sys_rst) // RULE_03
        (state_reg == S_EXEC && kind_reg == K_HI && wr_idx_reg == 3'h0)
        |=> prereg.feed_amount == {$past(word_in), $past(lo_reg)})
        else $error("feed amount write wrong");
    a_stop_sticky: assert property (@(posedge clk) disable iff (sys_rst) // RULE_19
        axis_state.stop_pulse |=> stop_end_reg ##1 status_low_byte_port[ST_STOP_END])
        else $error("stop end not held");
    a_any_irq: assert property (@(posedge clk) disable iff (sys_rst) // RULE_18
        (axis_state.irq_masked && $past(axis_state.irq_masked) == 1'b1)
        |=> status_low_byte_port[ST_ANY_IRQ] == 1'b0)
        else $error("masked interrupt shown");
    a_group_pins: assert property (@(posedge clk) disable iff (sys_rst) // RULE_20
        (!clock_align_enable && group_select_field == GROUP_FROM_PINS)
        |=> status_high_byte_port[6:4] == ~$past(grp_sync_reg))
        else $error("group status not from pins");
    a_pin_mask: assert property (@(posedge clk) disable iff (sys_rst) // RULE_13
        ##1 ((gp_pin_out & ~gp_pin_oe) == 8'h00))
        else $error("output on input terminal");
    a_wdt_clear: assert property (@(posedge clk) disable iff (sys_rst) // RULE_14
        (watchdog_timeout && wdc_sync_reg) |=> gp_output_data_port == GP_OUT_RST)
        else $error("watchdog clear missed");
endmodule
`default_nettype wire

//--- tb/center_model.sv
// Center-side model: queues a frame, sends it, collects the reply words
`timescale 1ns/10ps
`default_nettype none
module center_model (
    input  wire logic        clk,
    input  wire logic        frame_ready,
    input  wire logic        frame_done,
    input  wire logic        resp_valid,
    input  wire logic [15:0] resp_word,
    output logic             frame_valid,
    output logic [15:0]      frame_word,
    output logic             frame_end
);
    logic [15:0] tx[$];
    logic [15:0] rx[$];
    initial
    begin
        frame_valid = 1'b0;
        frame_word  = 16'hFFFF;
        frame_end   = 1'b0;
    end
    always @(posedge clk)
        if (resp_valid)
            rx.push_back(resp_word);
    // Frame is fully queued before sending starts; writes queued cmd, low, high
    task automatic run(output bit ok);
        int n;
        n = 0;
        rx.delete();
        while (!frame_ready)
            @(posedge clk);
        for (int i = 0; i < tx.size() && i < 64; i++)
        begin
            @(posedge clk);
            frame_valid <= 1'b1;
            frame_word  <= tx[i];
            frame_end   <= (i == tx.size() - 1);
        end
        @(posedge clk);
        frame_valid <= 1'b0;
        frame_end   <= 1'b0;
        frame_word  <= ~frame_word;
        #1;
        while (!frame_done && n < 500)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        ok = frame_done;
        tx.delete();
    endtask
endmodule
`default_nettype wire

//--- tb/testbench.sv
// Self-checking bench for the axis frame node
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import axis_node_pkg::*;
    logic clk, sys_rst, fv, fe, fr, fd, rv, ena, selb, wdt, wclr, p3w, start;
    logic [15:0] fw, rw;
    logic [31:0] c1, c2, c3, mode_at;
    logic [2:0] gfield, gpins_n;
    logic [7:0] dir, p3d, gpo, gpi, sth, stl, pin_in, pin_out, pin_oe;
    prereg_set_t pr;
    axis_state_t ast;
    int n_mismatch, tests_run, starts;
    bit ok;
    assign pin_in = (pin_out & pin_oe) | (8'hC0 & ~pin_oe);
    center_model center_model_inst (.clk(clk), .frame_ready(fr), .frame_done(fd),
        .resp_valid(rv), .resp_word(rw), .frame_valid(fv), .frame_word(fw), .frame_end(fe));
    axis_frame_node axis_frame_node_inst (.clk(clk), .sys_rst(sys_rst), .frame_valid(fv),
        .frame_word(fw), .frame_end(fe), .frame_ready(fr), .frame_done(fd), .resp_valid(rv),
        .resp_word(rw), .counter_one(c1), .counter_two(c2), .counter_three(c3), .prereg(pr),
        .accel_cruise_decel_start(start), .axis_state(ast), .clock_align_enable(ena),
        .clock_align_select_b(selb), .group_select_field(gfield),
        .group_select_pins_n(gpins_n), .terminal_direction_bit(dir),
        .watchdog_timeout(wdt), .watchdog_output_clear_pin(wclr), .port3_write(p3w),
        .port3_data(p3d), .gp_output_data_port(gpo), .gp_input_data_port(gpi),
        .status_high_byte_port(sth), .status_low_byte_port(stl), .gp_pin_in(pin_in),
        .gp_pin_out(pin_out), .gp_pin_oe(pin_oe));
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk)
        if (start === 1'b1)
        begin
            starts++;
            mode_at <= pr.operation_mode;
        end
    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic wait_clk(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic t_writes;
        center_model_inst.tx = '{16'h00B0, 16'h4567, 16'h0123, 16'h00B1, 16'h0001, 16'h0000,
            16'h00B2, 16'h1000, 16'h0000, 16'h00B3, 16'h0010, 16'h0000, 16'h00B5, 16'h00C7,
            16'h0000, 16'h00B7, 16'h0041, 16'h0000, 16'h0053};
        center_model_inst.run(ok);
        check("done", ok, 1);
        check("feed", pr.feed_amount, 32'h0123_4567);
        check("low", pr.low_speed, 32'h0000_0001);
        check("high", pr.high_speed, 32'h0000_1000);
        check("accel", pr.accel_rate, 32'h0000_0010);
        check("scale", pr.speed_scale, 32'h0000_00C7);
        check("mode", pr.operation_mode, 32'h0000_0041);
        check("starts", starts, 1);
        check("mode_at", mode_at, 32'h0000_0041);
    endtask
    task automatic t_reads;
        logic [15:0] exp[9];
        exp = '{16'h00ED, 16'h4567, 16'h0123, 16'h00EE, 16'h4566, 16'h0123, 16'h00EF,
            16'h0001, 16'h0000};
        center_model_inst.tx = '{16'h0029, 16'h00ED, 16'h00EE, 16'h00EF};
        center_model_inst.run(ok);
        check("nresp", center_model_inst.rx.size(), 9);
        foreach (exp[i])
            check("resp", center_model_inst.rx[i], exp[i]);
    endtask
    task automatic t_ports;
        p3w <= 1'b1;
        p3d <= 8'hA5;
        wait_clk(1);
        p3w <= 1'b0;
        wait_clk(6);
        check("gpo", gpo, 8'hA5);
        check("oe", pin_oe, 8'h0F);
        check("pin_out", pin_out, 8'h05);
        check("gpi", gpi, 8'hC5);
        wclr <= 1'b1;
        wdt <= 1'b1;
        wait_clk(6);
        check("wdt", gpo, 8'h00);
    endtask
    task automatic t_status;
        check("sth", sth, 8'h51);
        check("stl", stl, 8'h45);
        ast.irq_masked <= 1'b1;
        ena <= 1'b1;
        selb <= 1'b1;
        wait_clk(4);
        check("sth_al", sth, 8'hAB);
        check("stl_al", stl, 8'h74);
    endtask
    // Stop pulse and event, then clear command and a write with its upper word left out
    task automatic t_irq;
        ast.irq_masked <= 1'b0;
        ena <= 1'b0;
        selb <= 1'b0;
        gfield <= 3'h3;
        ast.event_flag <= 1'b1;
        ast.stop_pulse <= 1'b1;
        wait_clk(1);
        ast.stop_pulse <= 1'b0;
        wait_clk(3);
        check("stl_stop", stl, 8'h4F);
        check("sth_grp", sth, 8'h31);
        center_model_inst.tx = '{16'h0008, 16'h00B7, 16'h0042};
        center_model_inst.run(ok);
        wait_clk(2);
        check("done_clr", ok, 1);
        check("stl_clr", stl, 8'h4D);
        check("mode_lo", pr.operation_mode, 32'h0000_0042);
    endtask
    initial
    begin
        {ena, selb, wdt, wclr, p3w, starts, n_mismatch, tests_run} = '0;
        {c1, c2, c3, p3d} = {32'h0123_4567, 32'h0123_4566, 32'h0000_0001, 8'h00};
        ast = '0;
        ast.error_flag = 1'b1;
        ast.busy = 1'b1;
        ast.op_prereg_full = 1'b1;
        ast.sim_stop_bits = 2'b11;
        ast.clock_align_status = 7'h55;
        {gfield, gpins_n, dir} = {3'h0, 3'h2, 8'h0F};
        sys_rst = 1'b1;
        wait_clk(4);
        sys_rst <= 1'b0;
        t_writes();
        t_reads();
        t_ports();
        t_status();
        t_irq();
        summarize();
    end
    initial
    begin
        #200000;
        n_mismatch++;
        summarize();
    end
endmodule
`default_nettype wire
